// >>> include/asr_pkg.sv
// Overview of operation
// - bit 15 follows scan-done flag level
// - reset alert resets to one, others zero
// - reset alert clears on written zero only
// - mismatch bit sets when spread exceeds threshold
// - mismatch bit clears at next clean acquisition
// - bit 12 ORs cell over alerts
// - bit 11 ORs cell under alerts
// - cell/aux summaries clear at resolved acquisition
// - bit 10 block over, updated per acquisition
// - bit 9 block under, updated per acquisition
// - bit 8 ORs aux over alerts
// - bit 7 ORs aux under alerts
// - packet summary clears with its components
// - CRC error in response bit 31 and in the bit 5 packet summary
// - bit 4 ORs mode-specific interface errors
// - bit 3 ORs calibration alerts
// - bit 2 ORs enabled balancing alerts
// - bits 1/0 OR failure-check registers
package asr_pkg;
    // register offset on the host register port
    localparam logic [7:0] ALERT_STATUS_SUMMARY_OFS = 8'h02;
    localparam logic [15:0] SUMMARY_RST = 16'h4000;
    // summary bit positions
    localparam int BIT_SCAN = 15;
    localparam int BIT_RST = 14;
    localparam int BIT_MSMTCH = 13;
    localparam int BIT_CELL_OV = 12;
    localparam int BIT_CELL_UV = 11;
    localparam int BIT_BLK_OV = 10;
    localparam int BIT_BLK_UV = 9;
    localparam int BIT_AUX_OV = 8;
    localparam int BIT_AUX_UV = 7;
    localparam int BIT_PEC = 5;
    localparam int BIT_INTF = 4;
    localparam int BIT_CAL = 3;
    localparam int BIT_BAL = 2;
    localparam int BIT_FAIL2 = 1;
    localparam int BIT_FAIL1 = 0;
    // interface status register layout
    localparam int IFS_PEC_UP = 15;
    localparam int IFS_PEC_DN = 14;
    localparam logic [15:0] IFS_UART_ERR_MASK = 16'h3E01;
    localparam logic [15:0] IFS_SPI_ERR_MASK = 16'h00F1;
    // widths
    localparam int VOLT_W = 16;
    localparam int AUX_N = 6;
    localparam int CAL_N = 5;
    localparam int BAL_N = 5;
endpackage : asr_pkg

// >>> hdl/asr_hold_or.sv
`timescale 1ns/1ps
// summary flag: sets as soon as any source is up, drops only at an
// acquisition strobe that finds every source resolved
module asr_hold_or #(
    parameter int W = 28
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_src,
    input wire logic i_acq,
    output logic o_flag
);
    typedef struct packed {
        logic flag;
    } asr_hold_state_type;

    asr_hold_state_type cur;
    asr_hold_state_type next_cur;

    // set beats the acquisition clear when both land together
    always_comb
    begin
        next_cur = cur;
        next_cur.flag = (|i_src) | (cur.flag & ~i_acq);
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign o_flag = cur.flag;
endmodule : asr_hold_or

// >>> hdl/asr_acq_cmp.sv
`timescale 1ns/1ps
// compare flag re-evaluated only on its acquisition strobe
module asr_acq_cmp #(
    parameter int W = 16,
    parameter bit OVER = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_value,
    input wire logic [W-1:0] i_limit,
    input wire logic i_acq,
    output logic o_flag
);
    typedef struct packed {
        logic flag;
    } asr_cmp_state_type;

    asr_cmp_state_type cur;
    asr_cmp_state_type next_cur;
    logic hit;

    // strictly above or strictly below, depending on the direction
    always_comb
    begin
        hit = OVER ? (i_value > i_limit) : (i_value < i_limit);
        next_cur = cur;
        if (i_acq)
            next_cur.flag = hit;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign o_flag = cur.flag;
endmodule : asr_acq_cmp

// >>> hdl/asr_summary.sv
`timescale 1ns/1ps
// alert status summary register: one 16-bit word of alert summaries
module asr_summary (
    input wire logic i_clk,
    input wire logic i_rst_b,
    // host register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // scan control
    input wire logic i_scan_done_flag,
    // cell acquisition
    input wire logic i_cell_acq,
    input wire logic [15:0] i_cell_max,
    input wire logic [15:0] i_cell_min,
    input wire logic [15:0] i_mismatch_threshold,
    input wire logic [14:1] i_cell_adc_over_alerts,
    input wire logic [14:1] i_cell_comparator_over_alerts,
    input wire logic [14:1] i_cell_adc_under_alerts,
    input wire logic [14:1] i_cell_comparator_under_alerts,
    // auxiliary acquisition
    input wire logic i_aux_acq,
    input wire logic [5:0] i_aux_adc_over_alerts,
    input wire logic [5:0] i_aux_comparator_over_alerts,
    input wire logic [5:0] i_aux_adc_under_alerts,
    input wire logic [5:0] i_aux_comparator_under_alerts,
    // block acquisition
    input wire logic i_block_acq,
    input wire logic [15:0] i_block_voltage,
    input wire logic [15:0] i_block_over_threshold,
    input wire logic [15:0] i_block_under_threshold,
    // interface unit
    input wire logic i_interface_select,
    input wire logic [15:0] i_interface_status_reg,
    input wire logic i_serial_crc_error,
    input wire logic i_serial_alert_clear,
    // calibration, balancing, failure checks
    input wire logic [4:0] i_cal_alerts,
    input wire logic [4:0] i_bal_alerts,
    input wire logic [4:0] i_bal_enable,
    input wire logic [15:0] i_failure_check1_reg,
    input wire logic [15:0] i_failure_check2_reg,
    // outputs
    output logic [15:0] o_alert_status_summary,
    output logic o_response_status_bit,
    output logic o_transaction_discard
);
    typedef struct packed {
        logic rst_alert;
        logic scan;
        logic pec;
        logic intf;
        logic cal;
        logic bal;
        logic fail2;
        logic fail1;
        logic crc_flag;
        logic rvalid;
        logic [15:0] rdata;
    } asr_main_state_type;

    asr_main_state_type cur;
    asr_main_state_type next_cur;

    logic wr_hit;
    logic rd_hit;
    logic [15:0] spread;
    logic [15:0] summary;
    logic mismatch_flag;
    logic cell_ov_flag;
    logic cell_uv_flag;
    logic aux_ov_flag;
    logic aux_uv_flag;
    logic blk_ov_flag;
    logic blk_uv_flag;

    assign wr_hit = i_reg_wr && (i_reg_addr == asr_pkg::ALERT_STATUS_SUMMARY_OFS);
    assign rd_hit = i_reg_rd && (i_reg_addr == asr_pkg::ALERT_STATUS_SUMMARY_OFS);

    // spread clamps at zero so a stale max below min cannot wrap high
    assign spread = (i_cell_max > i_cell_min) ? (i_cell_max - i_cell_min) : 16'h0000;

    // mismatch re-judged on each cell acquisition
    asr_acq_cmp #(.W(asr_pkg::VOLT_W), .OVER(1'b1)) u_mismatch (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_value(spread),
        .i_limit(i_mismatch_threshold),
        .i_acq(i_cell_acq),
        .o_flag(mismatch_flag)
    );

    // block limits judged on each block acquisition
    asr_acq_cmp #(.W(asr_pkg::VOLT_W), .OVER(1'b1)) u_blk_ov (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_value(i_block_voltage),
        .i_limit(i_block_over_threshold),
        .i_acq(i_block_acq),
        .o_flag(blk_ov_flag)
    );

    asr_acq_cmp #(.W(asr_pkg::VOLT_W), .OVER(1'b0)) u_blk_uv (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_value(i_block_voltage),
        .i_limit(i_block_under_threshold),
        .i_acq(i_block_acq),
        .o_flag(blk_uv_flag)
    );

    // cell and aux summaries hold until an acquisition finds them clean
    asr_hold_or #(.W(28)) u_cell_ov (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_src({i_cell_adc_over_alerts, i_cell_comparator_over_alerts}),
        .i_acq(i_cell_acq),
        .o_flag(cell_ov_flag)
    );

    asr_hold_or #(.W(28)) u_cell_uv (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_src({i_cell_adc_under_alerts, i_cell_comparator_under_alerts}),
        .i_acq(i_cell_acq),
        .o_flag(cell_uv_flag)
    );

    asr_hold_or #(.W(2 * asr_pkg::AUX_N)) u_aux_ov (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_src({i_aux_adc_over_alerts, i_aux_comparator_over_alerts}),
        .i_acq(i_aux_acq),
        .o_flag(aux_ov_flag)
    );

    asr_hold_or #(.W(2 * asr_pkg::AUX_N)) u_aux_uv (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_src({i_aux_adc_under_alerts, i_aux_comparator_under_alerts}),
        .i_acq(i_aux_acq),
        .o_flag(aux_uv_flag)
    );

    // assemble the word; bit 6 is wired to zero
    always_comb
    begin
        summary = 16'h0000;
        summary[asr_pkg::BIT_SCAN] = cur.scan;
        summary[asr_pkg::BIT_RST] = cur.rst_alert;
        summary[asr_pkg::BIT_MSMTCH] = mismatch_flag;
        summary[asr_pkg::BIT_CELL_OV] = cell_ov_flag;
        summary[asr_pkg::BIT_CELL_UV] = cell_uv_flag;
        summary[asr_pkg::BIT_BLK_OV] = blk_ov_flag;
        summary[asr_pkg::BIT_BLK_UV] = blk_uv_flag;
        summary[asr_pkg::BIT_AUX_OV] = aux_ov_flag;
        summary[asr_pkg::BIT_AUX_UV] = aux_uv_flag;
        summary[asr_pkg::BIT_PEC] = cur.pec;
        summary[asr_pkg::BIT_INTF] = cur.intf;
        summary[asr_pkg::BIT_CAL] = cur.cal;
        summary[asr_pkg::BIT_BAL] = cur.bal;
        summary[asr_pkg::BIT_FAIL2] = cur.fail2;
        summary[asr_pkg::BIT_FAIL1] = cur.fail1;
    end

    // next state; OR summaries are re-registered every clock
    always_comb
    begin
        next_cur = cur;
        next_cur.scan = i_scan_done_flag;
        // only a written zero clears; a written one is ignored
        if (wr_hit && !i_reg_wdata[asr_pkg::BIT_RST])
            next_cur.rst_alert = 1'b0;
        // crc error is held for the response word; set wins over clear
        next_cur.crc_flag = i_serial_crc_error | (cur.crc_flag & ~i_serial_alert_clear);
        next_cur.pec = i_interface_status_reg[asr_pkg::IFS_PEC_UP]
            | i_interface_status_reg[asr_pkg::IFS_PEC_DN]
            | i_serial_crc_error | cur.crc_flag;
        if (i_interface_select)
            next_cur.intf = |(i_interface_status_reg & asr_pkg::IFS_UART_ERR_MASK);
        else
            next_cur.intf = |(i_interface_status_reg & asr_pkg::IFS_SPI_ERR_MASK);
        next_cur.cal = |i_cal_alerts;
        next_cur.bal = |(i_bal_alerts & i_bal_enable);
        next_cur.fail2 = |i_failure_check2_reg;
        next_cur.fail1 = |i_failure_check1_reg;
        next_cur.rvalid = rd_hit;
        if (rd_hit)
            next_cur.rdata = summary;
    end

    // reset is the power-on event: it raises the reset alert
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            cur <= '0;
            cur.rst_alert <= asr_pkg::SUMMARY_RST[asr_pkg::BIT_RST];
        end
        else
            cur <= next_cur;
    end

    assign o_alert_status_summary = summary;
    assign o_reg_rdata = cur.rdata;
    assign o_reg_rvalid = cur.rvalid;
    assign o_response_status_bit = cur.crc_flag;
    // a frame that failed its check is dropped by the interface unit
    assign o_transaction_discard = i_serial_crc_error;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // reset alert: raised by reset, dropped only by a written zero
    rst_alert_clear_a: assert property (
        wr_hit && !i_reg_wdata[asr_pkg::BIT_RST] |=> !summary[asr_pkg::BIT_RST])
        else $error("reset alert not cleared by zero write");
    rst_alert_keep_a: assert property (
        summary[asr_pkg::BIT_RST] && !(wr_hit && !i_reg_wdata[asr_pkg::BIT_RST])
        |=> summary[asr_pkg::BIT_RST])
        else $error("reset alert lost without zero write");
    reset_value_a: assert property (
        $rose(i_rst_b) |-> summary == asr_pkg::SUMMARY_RST)
        else $error("summary reset value wrong");
    scan_follow_a: assert property (
        1'b1 |=> summary[asr_pkg::BIT_SCAN] == $past(i_scan_done_flag))
        else $error("scan bit not following flag");
    // bits judged only on their acquisition strobe
    mismatch_set_a: assert property (
        i_cell_acq && (spread > i_mismatch_threshold) |=> summary[asr_pkg::BIT_MSMTCH])
        else $error("mismatch not flagged");
    mismatch_clear_a: assert property (
        i_cell_acq && !(spread > i_mismatch_threshold) |=> !summary[asr_pkg::BIT_MSMTCH])
        else $error("mismatch not cleared");
    block_ov_a: assert property (
        i_block_acq |=> summary[asr_pkg::BIT_BLK_OV]
        == ($past(i_block_voltage) > $past(i_block_over_threshold)))
        else $error("block over bit wrong");
    block_uv_a: assert property (
        i_block_acq |=> summary[asr_pkg::BIT_BLK_UV]
        == ($past(i_block_voltage) < $past(i_block_under_threshold)))
        else $error("block under bit wrong");
    block_hold_a: assert property (
        !i_block_acq |=> $stable(summary[asr_pkg::BIT_BLK_OV:asr_pkg::BIT_BLK_UV]))
        else $error("block bits moved without acquisition");
    // held cell and aux summaries
    cell_ov_set_a: assert property (
        (|i_cell_comparator_over_alerts) |=> summary[asr_pkg::BIT_CELL_OV])
        else $error("cell over summary missed");
    cell_ov_hold_a: assert property (
        summary[asr_pkg::BIT_CELL_OV] && !i_cell_acq |=> summary[asr_pkg::BIT_CELL_OV])
        else $error("cell over summary dropped between acquisitions");
    cell_ov_clear_a: assert property (
        i_cell_acq && !(|i_cell_adc_over_alerts) && !(|i_cell_comparator_over_alerts)
        |=> !summary[asr_pkg::BIT_CELL_OV])
        else $error("cell over summary not cleared");
    cell_uv_set_a: assert property (
        (|i_cell_adc_under_alerts) |=> summary[asr_pkg::BIT_CELL_UV])
        else $error("cell under summary missed");
    cell_uv_hold_a: assert property (
        summary[asr_pkg::BIT_CELL_UV] && !i_cell_acq |=> summary[asr_pkg::BIT_CELL_UV])
        else $error("cell under summary dropped between acquisitions");
    aux_ov_set_a: assert property (
        (|i_aux_adc_over_alerts) || (|i_aux_comparator_over_alerts)
        |=> summary[asr_pkg::BIT_AUX_OV])
        else $error("aux over summary missed");
    aux_uv_set_a: assert property (
        (|i_aux_comparator_under_alerts) |=> summary[asr_pkg::BIT_AUX_UV])
        else $error("aux under summary missed");
    aux_uv_clear_a: assert property (
        i_aux_acq && !(|i_aux_adc_under_alerts) && !(|i_aux_comparator_under_alerts)
        |=> !summary[asr_pkg::BIT_AUX_UV])
        else $error("aux under summary not cleared");
    // packet-check and interface summaries
    pec_set_a: assert property (
        i_interface_status_reg[asr_pkg::IFS_PEC_UP]
        || i_interface_status_reg[asr_pkg::IFS_PEC_DN] |=> summary[asr_pkg::BIT_PEC])
        else $error("packet check summary missed");
    pec_clear_a: assert property (
        !i_interface_status_reg[asr_pkg::IFS_PEC_UP]
        && !i_interface_status_reg[asr_pkg::IFS_PEC_DN]
        && !i_serial_crc_error && !o_response_status_bit |=> !summary[asr_pkg::BIT_PEC])
        else $error("packet check summary not cleared");
    crc_resp_a: assert property (
        i_serial_crc_error |=> o_response_status_bit && summary[asr_pkg::BIT_PEC])
        else $error("crc error not reported");
    crc_hold_a: assert property (
        o_response_status_bit && !i_serial_alert_clear |=> o_response_status_bit)
        else $error("response bit dropped without clear");
    intf_uart_a: assert property (
        i_interface_select |=> summary[asr_pkg::BIT_INTF]
        == |($past(i_interface_status_reg) & asr_pkg::IFS_UART_ERR_MASK))
        else $error("uart interface summary wrong");
    intf_spi_a: assert property (
        !i_interface_select |=> summary[asr_pkg::BIT_INTF]
        == |($past(i_interface_status_reg) & asr_pkg::IFS_SPI_ERR_MASK))
        else $error("serial interface summary wrong");
    // plain OR summaries, one clock behind their sources
    cal_or_a: assert property (
        1'b1 |=> summary[asr_pkg::BIT_CAL] == (|$past(i_cal_alerts)))
        else $error("calibration summary wrong");
    bal_or_a: assert property (
        1'b1 |=> summary[asr_pkg::BIT_BAL] == |($past(i_bal_alerts) & $past(i_bal_enable)))
        else $error("balancing summary wrong");
    fail_or_a: assert property (
        1'b1 |=> summary[asr_pkg::BIT_FAIL2:asr_pkg::BIT_FAIL1]
        == {|$past(i_failure_check2_reg), |$past(i_failure_check1_reg)})
        else $error("failure check summaries wrong");
    bit6_zero_a: assert property (
        summary[6] == 1'b0)
        else $error("bit 6 not zero");
    // register port
    read_data_a: assert property (
        rd_hit |=> o_reg_rvalid && (o_reg_rdata == $past(summary)))
        else $error("read data not the summary word");
    no_read_a: assert property (
        !rd_hit |=> !o_reg_rvalid)
        else $error("read valid without a summary read");

    rst_cleared_c: cover property (
        wr_hit && !i_reg_wdata[asr_pkg::BIT_RST] ##1 !summary[asr_pkg::BIT_RST]);
    scan_done_c: cover property ($rose(summary[asr_pkg::BIT_SCAN]));
    mismatch_c: cover property (
        $rose(summary[asr_pkg::BIT_MSMTCH]) ##[1:20] $fell(summary[asr_pkg::BIT_MSMTCH]));
    crc_clear_c: cover property ($fell(o_response_status_bit));
endmodule : asr_summary

// >>> test/asr_summary_tb.sv
`timescale 1ns/1ps
module asr_summary_tb;
    logic i_clk, i_rst_b, i_reg_wr, i_reg_rd, i_scan_done_flag, i_cell_acq, i_aux_acq;
    logic i_block_acq, i_interface_select, i_serial_crc_error, i_serial_alert_clear;
    logic [7:0] i_reg_addr;
    logic [15:0] i_reg_wdata, i_cell_max, i_cell_min, i_mismatch_threshold, i_block_voltage;
    logic [15:0] i_block_over_threshold, i_block_under_threshold, i_interface_status_reg;
    logic [15:0] i_failure_check1_reg, i_failure_check2_reg, o_reg_rdata, o_alert_status_summary;
    logic [14:1] i_cell_adc_over_alerts, i_cell_comparator_over_alerts;
    logic [14:1] i_cell_adc_under_alerts, i_cell_comparator_under_alerts;
    logic [5:0] i_aux_adc_over_alerts, i_aux_comparator_over_alerts;
    logic [5:0] i_aux_adc_under_alerts, i_aux_comparator_under_alerts;
    logic [4:0] i_cal_alerts, i_bal_alerts, i_bal_enable;
    logic o_reg_rvalid, o_response_status_bit, o_transaction_discard;
    logic [15:0] exp_q[$];
    int err_count;
    int cmp_count;
    logic [15:0] note;
    int pos[12] = '{12, 12, 11, 11, 8, 8, 7, 7, 3, 2, 0, 1};
    logic [15:0] bv[4] = '{16'h8001, 16'h8000, 16'h3FFF, 16'h4000};
    logic [15:0] be[4] = '{16'h0400, 16'h0000, 16'h0200, 16'h0000};
    logic [6:0] ms = 7'b0011001;
    logic [15:0] ist[7] = '{16'h2000, 16'h2000, 16'h0080, 16'h0080, 16'h8000, 16'h4000, 16'h0001};
    logic [15:0] ie[7] = '{16'h0010, 16'h0000, 16'h0010, 16'h0000, 16'h0020, 16'h0020, 16'h0010};

    asr_summary DUT (.*);

    // free-running 10 MHz clock
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc

    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk16

    task automatic chk1(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask : chk1

    task automatic conclude();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        cyc(1);
        i_reg_wr = 1'b0;
    endtask : reg_wr

    // two idle cycles first so one-cycle-late summaries have landed
    task automatic expect_rd(input logic [7:0] a, input logic [15:0] e);
        cyc(2);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        if (a == asr_pkg::ALERT_STATUS_SUMMARY_OFS)
            exp_q.push_back(e);
        cyc(1);
        i_reg_rd = 1'b0;
    endtask : expect_rd

    // strobe one acquisition or clear input for a single cycle
    task automatic pulse(input int w);
        case (w)
            0: i_cell_acq = 1'b1;
            1: i_aux_acq = 1'b1;
            2: i_block_acq = 1'b1;
            default: i_serial_alert_clear = 1'b1;
        endcase
        cyc(1);
        {i_cell_acq, i_aux_acq, i_block_acq, i_serial_alert_clear} = '0;
    endtask : pulse

    task automatic set_src(input int k, input logic v, input int i);
        case (k)
            0: i_cell_adc_over_alerts[i + 10] = v;
            1: i_cell_comparator_over_alerts[i + 10] = v;
            2: i_cell_adc_under_alerts[i + 10] = v;
            3: i_cell_comparator_under_alerts[i + 10] = v;
            4: i_aux_adc_over_alerts[i + 1] = v;
            5: i_aux_comparator_over_alerts[i + 1] = v;
            6: i_aux_adc_under_alerts[i + 1] = v;
            7: i_aux_comparator_under_alerts[i + 1] = v;
            8: i_cal_alerts[i] = v;
            9: i_bal_alerts[i] = v;
            10: i_failure_check1_reg[i + 11] = v;
            default: i_failure_check2_reg[i + 11] = v;
        endcase
    endtask : set_src

    // read monitor: every rvalid takes the oldest note off the queue
    always @(negedge i_clk)
    begin
        if (o_reg_rvalid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk1("rvalid", 1'b0, o_reg_rvalid);
            else
            begin
                note = exp_q.pop_front();
                chk16("rdata", note, o_reg_rdata);
                chk16("summary", note, o_alert_status_summary);
            end
        end
    end

    // watchdog so a stuck run still reaches the verdict
    initial
    begin
        repeat (6000) @(posedge i_clk);
        chk1("watchdog", 1'b0, 1'b1);
        conclude();
    end

    // main sequence; inputs move on the falling edge only
    initial
    begin
        int idx;
        logic [15:0] thr;
        void'($urandom(3147));
        {i_rst_b, i_reg_wr, i_reg_rd, i_scan_done_flag, i_cell_acq, i_aux_acq} = '0;
        {i_block_acq, i_interface_select, i_serial_crc_error, i_serial_alert_clear} = '0;
        {i_reg_addr, i_reg_wdata, i_cell_max, i_cell_min, i_mismatch_threshold} = '0;
        {i_cell_adc_over_alerts, i_cell_comparator_over_alerts} = '0;
        {i_cell_adc_under_alerts, i_cell_comparator_under_alerts} = '0;
        {i_aux_adc_over_alerts, i_aux_comparator_over_alerts} = '0;
        {i_aux_adc_under_alerts, i_aux_comparator_under_alerts} = '0;
        {i_interface_status_reg, i_failure_check1_reg, i_failure_check2_reg} = '0;
        {i_cal_alerts, i_bal_alerts} = '0;
        i_bal_enable = 5'h1F;
        i_block_voltage = 16'h6000;
        i_block_over_threshold = 16'h8000;
        i_block_under_threshold = 16'h4000;
        cyc(4);
        i_rst_b = 1'b1;
        expect_rd(8'h02, 16'h4000);
        reg_wr(8'h02, 16'hFFFF);
        expect_rd(8'h02, 16'h4000);
        reg_wr(8'h03, 16'h0000);
        expect_rd(8'h03, 16'h0000);
        expect_rd(8'h02, 16'h4000);
        reg_wr(8'h02, 16'hBFFF);
        expect_rd(8'h02, 16'h0000);
        i_scan_done_flag = 1'b1;
        expect_rd(8'h02, 16'h8000);
        i_scan_done_flag = 1'b0;
        expect_rd(8'h02, 16'h0000);
        // one source of each cell, aux, calibration, balancing and failure-check summary in turn; held ones wait for an acquisition
        for (int k = 0; k < 12; k++)
        begin
            idx = $urandom_range(4, 0);
            set_src(k, 1'b1, idx);
            expect_rd(8'h02, 16'h0001 << pos[k]);
            set_src(k, 1'b0, idx);
            if (k < 8)
            begin
                expect_rd(8'h02, 16'h0001 << pos[k]);
                if (k < 4)
                    pulse(0);
                else
                    pulse(1);
            end
            expect_rd(8'h02, 16'h0000);
        end
        i_bal_enable = 5'h00;
        i_bal_alerts = 5'h1F;
        expect_rd(8'h02, 16'h0000);
        i_bal_alerts = 5'h00;
        // spread one above threshold, then exactly at it
        thr = 16'($urandom_range(16'h0100, 16'h0010));
        i_mismatch_threshold = thr;
        i_cell_min = 16'($urandom_range(16'h4000, 16'h1000));
        i_cell_max = i_cell_min + thr + 16'h0001;
        pulse(0);
        expect_rd(8'h02, 16'h2000);
        i_cell_max = i_cell_min + thr;
        expect_rd(8'h02, 16'h2000);
        pulse(0);
        expect_rd(8'h02, 16'h0000);
        // block flags move only on their own acquisition
        for (int j = 0; j < 4; j++)
        begin
            i_block_voltage = bv[j];
            expect_rd(8'h02, (j == 0) ? 16'h0000 : be[j - 1]);
            pulse(2);
            expect_rd(8'h02, be[j]);
        end
        for (int j = 0; j < 7; j++)
        begin
            i_interface_select = ms[j];
            i_interface_status_reg = ist[j];
            expect_rd(8'h02, ie[j]);
        end
        i_interface_status_reg = 16'h0000;
        expect_rd(8'h02, 16'h0000);
        i_serial_crc_error = 1'b1;
        #1;
        chk1("discard", 1'b1, o_transaction_discard);
        cyc(1);
        i_serial_crc_error = 1'b0;
        chk1("response", 1'b1, o_response_status_bit);
        expect_rd(8'h02, 16'h0020);
        pulse(3);
        expect_rd(8'h02, 16'h0000);
        chk1("response", 1'b0, o_response_status_bit);
        i_rst_b = 1'b0;
        cyc(2);
        i_rst_b = 1'b1;
        expect_rd(8'h02, 16'h4000);
        reg_wr(8'h02, 16'h0000);
        expect_rd(8'h02, 16'h0000);
        for (int t = 0; t < 10 && exp_q.size() > 0; t++)
            cyc(1);
        if (exp_q.size() > 0)
            chk1("drain", 1'b0, 1'b1);
        conclude();
    end
endmodule : asr_summary_tb
